// file: design/sdp_regs.svh
// sdp_regs.svh: address-line fields, mode defaults and timing counts
// for the sdram pin interface pair.
// assumes inclusion by bare name from the package and both ends.
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

// address line that carries the auto precharge / all-bank select
`define SDP_AP_BIT      10
// mode op-code fields on the address lines
`define SDP_BL_LSB      0
`define SDP_BL_MSB      2
`define SDP_CL_LSB      4
`define SDP_CL_MSB      6
// burst code for full page, cas latency code for three
`define SDP_BL_FULL     3'h7
`define SDP_CL_THREE    3'h3
// mode after reset and the one the controller loads: burst 1, latency 2
`define SDP_MODE_RST    12'h020
// controller wait counts in clock cycles
`define SDP_TRCD_CYC    2
`define SDP_TRP_CYC     2
`define SDP_RD_WAIT     2'h2

`endif

// file: design/sdp_pkg.sv
// sdp_pkg.sv: shared types for the sdram pin interface pair.
// assumes sdp_regs.svh is on the include path.
package sdp_pkg;
  `include "sdp_regs.svh"

  // command code as {chip select, row strobe, column strobe, write strobe}
  typedef enum logic [3:0] {
    CMD_LMR  = 4'h0,
    CMD_REF  = 4'h1,
    CMD_PRE  = 4'h2,
    CMD_ACT  = 4'h3,
    CMD_WR   = 4'h4,
    CMD_RD   = 4'h5,
    CMD_BST  = 4'h6,
    CMD_NOP  = 4'h7,
    CMD_DESL = 4'h8
  } sdp_cmd_t;

  // device clocking state
  typedef enum logic [2:0] {
    PS_RUN  = 3'h1,
    PS_PDN  = 3'h2,
    PS_SREF = 3'h4
  } sdp_pwr_t;

  // controller sequence
  typedef enum logic [6:0] {
    CS_INIT = 7'h01,
    CS_IDLE = 7'h02,
    CS_RCD  = 7'h04,
    CS_RW   = 7'h08,
    CS_RDW  = 7'h10,
    CS_PRE  = 7'h20,
    CS_SLP  = 7'h40
  } sdp_cst_t;
endpackage

// file: design/sdp_if.sv
// sdp_if.sv: pin bundle between controller and device.
// assumes both ends share clk; the data bus level is worked out here.
`timescale 1ns/1ps
interface sdp_if #(
  parameter int DQ_W = 16
) ();
  localparam int NL = (DQ_W == 16) ? 2 : 1;

  logic            clock_gate;
  logic            chip_sel_n;
  logic            row_strobe_n;
  logic            column_strobe_n;
  logic            write_strobe_n;
  logic [1:0]      bank_select;
  logic [11:0]     addr;
  logic            low_byte_mask;
  logic            high_byte_mask;
  logic [DQ_W-1:0] ctl_dq_out;
  logic            ctl_dq_oe;
  logic [DQ_W-1:0] dev_dq_out;
  logic [NL-1:0]   dev_dq_oe;
  logic [DQ_W-1:0] dq;

  // device lane enable wins; an undriven bit reads low
  for (genvar i = 0; i < DQ_W; i++) begin : g_dq
    assign dq[i] = dev_dq_oe[(NL == 2 && i >= 8) ? 1 : 0] ? dev_dq_out[i] :
                   ctl_dq_oe ? ctl_dq_out[i] : 1'b0;
  end

  modport ctl (
    output clock_gate, chip_sel_n, row_strobe_n, column_strobe_n,
    output write_strobe_n, bank_select, addr, low_byte_mask,
    output high_byte_mask, ctl_dq_out, ctl_dq_oe,
    input  dq
  );
  modport dev (
    input  clock_gate, chip_sel_n, row_strobe_n, column_strobe_n,
    input  write_strobe_n, bank_select, addr, low_byte_mask,
    input  high_byte_mask, dq,
    output dev_dq_out, dev_dq_oe
  );
endinterface

// file: design/sdp_dev.sv
// sdp_dev.sv: quad-bank synchronous dram end of the pin interface.
// assumes one clock shared with the controller; storage is a small
// slice of the array (low row and column bits only) to stay in flops.
//
// Overview of operation
// R01 - inputs captured only on rising clock edge
// R02 - burst counter, outputs advance each active edge
// R03 - clock gate low stops clocking, picks mode
// R04 - gate sensed immediately while in low power
// R05 - inputs ignored during power-down, self refresh
// R06 - controller may tie clock gate high
// R07 - deselected: no commands, bursts and masks continue
// R08 - command from four registered strobe levels
// R09 - masked write lane leaves location unchanged
// R10 - read mask floats outputs two cycles later
// R11 - x16 two lane masks, narrower one mask
// R12 - bank select picks target bank
// R13 - activate takes twelve address bits as row
// R14 - column bits depend on organisation
// R15 - auto precharge select closes bank after burst
// R16 - precharge with select high closes all banks
// R17 - load mode takes op-code from address lines
// R18 - burst lengths 1,2,4,8, full page, terminate
// R19 - controller activates row before read or write
// R20 - standard single data rate command encoding
`timescale 1ns/1ps
`include "sdp_regs.svh"
module sdp_dev
  import sdp_pkg::*;
#(
  parameter int DQ_W  = 16,
  parameter int ROW_W = 2,
  parameter int COL_W = 3
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  sdp_if.dev                      pins,
  output      sdp_pkg::sdp_pwr_t  power_state,
  output      logic [3:0]         bank_open
);
  import sdp_pkg::*;

  localparam int NL    = (DQ_W == 16) ? 2 : 1;
  localparam int WORDS = 4 << (ROW_W + COL_W);
  localparam int IW    = 2 + ROW_W + COL_W;

  typedef struct packed {
    sdp_pwr_t                      pstate;
    logic                          cke_reg;
    logic [3:0][11:0]              rows;
    logic [3:0]                    open;
    logic [2:0]                    bl_code;
    logic                          cl3;
    logic                          b_act;
    logic                          b_wr;
    logic                          b_ap;
    logic [1:0]                    b_bank;
    logic [10:0]                   b_col;
    logic [10:0]                   b_left;
    logic [1:0]                    rd_v;
    logic [1:0][DQ_W-1:0]          rd_d;
    logic [NL-1:0]                 dqm_d;
    logic [DQ_W-1:0]               dq_out;
    logic [NL-1:0]                 dq_oe;
    logic [WORDS-1:0][DQ_W-1:0]    mem;
  } sdp_dev_t;

  sdp_dev_t s_reg;
  sdp_dev_t s_next;

  // starting column per organisation
  function automatic logic [10:0] col_of(input logic [11:0] a);
    if (DQ_W == 4)
      col_of = {a[11], a[9:0]}; // [R14]
    else if (DQ_W == 8)
      col_of = {1'b0, a[9:0]}; // [R14]
    else
      col_of = {2'h0, a[8:0]}; // [R14]
  endfunction

  // wrap mask for the burst counter
  function automatic logic [10:0] wrap_of(input logic [2:0] code);
    if (code == `SDP_BL_FULL)
      wrap_of = (DQ_W == 4) ? 11'h7FF : (DQ_W == 8) ? 11'h3FF : 11'h1FF;
    else
      wrap_of = (11'h001 << code[1:0]) - 11'h001;
  endfunction

  // storage word index from bank, row and column
  function automatic logic [IW-1:0] idx_of(input logic [1:0] b,
                                           input logic [11:0] r,
                                           input logic [10:0] c);
    idx_of = {b, r[ROW_W-1:0], c[COL_W-1:0]};
  endfunction

  sdp_cmd_t      cmd;
  logic [NL-1:0] dqm_in;
  logic [2:0]    bl_new;

  // lane masks: the x16 splits lanes, narrower parts use the high mask
  always_comb begin
    dqm_in = {NL{pins.high_byte_mask}}; // [R11]
    if (NL == 2)
      dqm_in[0] = pins.low_byte_mask; // [R11]
  end

  // deselect masks the command decoder but not bursts or masks
  always_comb begin
    if (pins.chip_sel_n)
      cmd = CMD_NOP; // [R07]
    else
      cmd = sdp_cmd_t'({1'b0, pins.row_strobe_n, pins.column_strobe_n,
                        pins.write_strobe_n}); // [R08] [R20]
  end

  assign bl_new = pins.addr[`SDP_BL_MSB:`SDP_BL_LSB];

  // one pass per edge: command, read pipe, burst step, clock gating
  always_comb begin
    logic          acc;
    logic [IW-1:0] ix;
    logic [10:0]   wm;
    logic          sel;
    acc = 1'b0;
    ix  = '0;
    wm  = '0;
    sel = 1'b0;
    s_next = s_reg;
    s_next.cke_reg = pins.clock_gate;
    case (s_reg.pstate)
      PS_RUN: begin
        // a low gate seen last edge freezes this one: clock suspend
        if (s_reg.cke_reg) begin // [R03]
          s_next.dqm_d = dqm_in;
          case (cmd)
            CMD_ACT: begin
              s_next.open[pins.bank_select] = 1'b1; // [R12]
              s_next.rows[pins.bank_select] = pins.addr; // [R13]
            end
            CMD_PRE: begin
              if (pins.addr[`SDP_AP_BIT])
                s_next.open = 4'h0; // [R16]
              else
                s_next.open[pins.bank_select] = 1'b0; // [R16] [R12]
            end
            CMD_LMR: begin
              s_next.bl_code = bl_new; // [R17] [R18]
              s_next.cl3 = pins.addr[`SDP_CL_MSB:`SDP_CL_LSB] ==
                           `SDP_CL_THREE; // [R17]
            end
            CMD_BST: s_next.b_act = 1'b0; // [R18]
            CMD_RD, CMD_WR: begin
              // a new access cuts off any burst in flight
              s_next.b_act  = 1'b1;
              s_next.b_wr   = (cmd == CMD_WR);
              s_next.b_ap   = pins.addr[`SDP_AP_BIT]; // [R15]
              s_next.b_bank = pins.bank_select; // [R12]
              s_next.b_col  = col_of(pins.addr); // [R14]
              s_next.b_left = wrap_of(s_reg.bl_code);
            end
            default: ;
          endcase
          acc = s_next.b_act;
          ix = idx_of(s_next.b_bank, s_next.rows[s_next.b_bank],
                      s_next.b_col);
          // write lanes whose mask is high keep their old bits
          if (acc && s_next.b_wr) begin
            for (int i = 0; i < DQ_W; i++) begin
              if (!dqm_in[(NL == 2 && i >= 8) ? 1 : 0])
                s_next.mem[ix][i] = pins.dq[i]; // [R09] [R11]
            end
          end
          // read pipe and output registers step every active edge
          s_next.rd_v = {s_reg.rd_v[0], acc && !s_next.b_wr}; // [R02]
          s_next.rd_d = {s_reg.rd_d[0], s_reg.mem[ix]};
          sel = s_reg.cl3;
          s_next.dq_out = s_reg.rd_d[sel]; // [R02]
          // mask sampled last edge floats lanes from this edge on
          s_next.dq_oe = {NL{s_reg.rd_v[sel]}} & ~s_reg.dqm_d; // [R10]
          // burst counter: wrap inside the burst, full page never ends
          if (acc) begin
            wm = wrap_of(s_reg.bl_code);
            s_next.b_col = (s_next.b_col & ~wm) |
                           ((s_next.b_col + 11'h001) & wm); // [R02] [R18]
            if (s_next.b_left == 11'h000 &&
                s_reg.bl_code != `SDP_BL_FULL) begin
              s_next.b_act = 1'b0;
              if (s_next.b_ap)
                s_next.open[s_next.b_bank] = 1'b0; // [R15]
            end else begin
              s_next.b_left = s_next.b_left - 11'h001;
            end
          end
          // gate low with nothing in flight: power-down or self refresh
          if (!pins.clock_gate && !s_next.b_act &&
              s_reg.rd_v == 2'h0 && s_next.rd_v == 2'h0) begin
            s_next.pstate = (cmd == CMD_REF) ? PS_SREF : PS_PDN; // [R03]
            s_next.dq_oe = '0;
          end
        end
      end
      // input buffers off: only the gate is watched, and it acts at once
      PS_PDN, PS_SREF: begin
        if (pins.clock_gate)
          s_next.pstate = PS_RUN; // [R04] [R05]
      end
      default: s_next.pstate = PS_RUN;
    endcase
  end

  // all state sampled on the rising edge only
  always_ff @(posedge clk) begin // [R01]
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.pstate <= PS_RUN;
      s_reg.cke_reg <= 1'b1;
      s_reg.bl_code <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.dev_dq_out = s_reg.dq_out;
  assign pins.dev_dq_oe  = s_reg.dq_oe;
  assign power_state     = s_reg.pstate;
  assign bank_open       = s_reg.open;
endmodule

// file: design/sdp_ctl.sv
// sdp_ctl.sv: memory controller end of the sdram pin interface.
// assumes one clock shared with the device; single-word closed-page
// accesses with auto precharge, burst 1 and cas latency 2.
`timescale 1ns/1ps
`include "sdp_regs.svh"
module sdp_ctl
  import sdp_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int TRCD = `SDP_TRCD_CYC,
  parameter int TRP  = `SDP_TRP_CYC
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  sdp_if.ctl                                       pins,
  input  wire logic                                req_valid,
  input  wire logic                                req_write,
  input  wire logic [1:0]                          req_bank,
  input  wire logic [11:0]                         req_row,
  input  wire logic [11:0]                         req_col,
  input  wire logic [DQ_W-1:0]                     req_wdata,
  input  wire logic [((DQ_W == 16) ? 2 : 1)-1:0]   req_mask,
  input  wire logic                                sleep_req,
  output      logic                                req_ready,
  output      logic                                rsp_valid,
  output      logic [DQ_W-1:0]                     rsp_rdata,
  output      logic                                asleep
);
  import sdp_pkg::*;

  localparam int NL = (DQ_W == 16) ? 2 : 1;

  typedef struct packed {
    sdp_cst_t        st;
    sdp_cmd_t        cmd;
    logic            cke;
    logic [1:0]      ba;
    logic [11:0]     addr;
    logic [11:0]     col;
    logic            wr;
    logic [NL-1:0]   dqm;
    logic [DQ_W-1:0] dq;
    logic            dq_oe;
    logic [3:0]      cnt;
    logic            ready;
    logic            rsp_v;
    logic [DQ_W-1:0] rsp_d;
  } sdp_ctl_t;

  sdp_ctl_t s_reg;
  sdp_ctl_t s_next;

  // one command per cycle, NOP between, row opened before access
  always_comb begin
    s_next = s_reg;
    s_next.cmd   = CMD_NOP;
    s_next.rsp_v = 1'b0;
    s_next.dq_oe = 1'b0;
    s_next.dqm   = '0;
    case (s_reg.st)
      CS_INIT: begin
        s_next.cmd  = CMD_LMR; // [R17] [R20]
        s_next.addr = `SDP_MODE_RST;
        s_next.st   = CS_PRE;
        s_next.cnt  = 4'(TRP);
      end
      CS_IDLE: begin
        if (sleep_req) begin
          s_next.cke   = 1'b0; // [R03]
          s_next.ready = 1'b0;
          s_next.st    = CS_SLP;
        end else if (req_valid && s_reg.ready) begin
          s_next.cmd   = CMD_ACT; // [R19]
          s_next.ba    = req_bank; // [R12]
          s_next.addr  = req_row; // [R13]
          s_next.col   = req_col;
          s_next.wr    = req_write;
          s_next.dq    = req_wdata;
          s_next.dqm   = req_mask;
          s_next.ready = 1'b0;
          s_next.cnt   = 4'(TRCD - 1);
          s_next.st    = CS_RCD;
        end
      end
      CS_RCD: begin
        s_next.dqm = s_reg.dqm;
        if (s_reg.cnt == 4'h0)
          s_next.st = CS_RW;
        else
          s_next.cnt = s_reg.cnt - 4'h1;
      end
      CS_RW: begin
        s_next.cmd  = s_reg.wr ? CMD_WR : CMD_RD; // [R08]
        s_next.addr = s_reg.col;
        s_next.addr[`SDP_AP_BIT] = 1'b1; // [R15]
        s_next.dq_oe = s_reg.wr;
        s_next.dqm   = s_reg.wr ? s_reg.dqm : '0; // [R09] [R10]
        s_next.cnt   = s_reg.wr ? 4'(TRP) : 4'(`SDP_RD_WAIT);
        s_next.st    = s_reg.wr ? CS_PRE : CS_RDW;
      end
      // data comes back two edges after the device takes the read
      CS_RDW: begin
        if (s_reg.cnt == 4'h0) begin
          s_next.rsp_v = 1'b1;
          s_next.rsp_d = pins.dq;
          s_next.cnt   = 4'(TRP);
          s_next.st    = CS_PRE;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      CS_PRE: begin
        if (s_reg.cnt == 4'h0) begin
          s_next.ready = 1'b1;
          s_next.st    = CS_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      // raising the gate wakes the device on its next edge
      CS_SLP: begin
        if (!sleep_req) begin
          s_next.cke   = 1'b1; // [R04]
          s_next.ready = 1'b1;
          s_next.st    = CS_IDLE;
        end
      end
      default: s_next.st = CS_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st  <= CS_INIT;
      s_reg.cmd <= CMD_NOP;
      s_reg.cke <= 1'b1; // [R06]
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.clock_gate      = s_reg.cke;
  assign pins.chip_sel_n      = s_reg.cmd[3];
  assign pins.row_strobe_n    = s_reg.cmd[2];
  assign pins.column_strobe_n = s_reg.cmd[1];
  assign pins.write_strobe_n  = s_reg.cmd[0];
  assign pins.bank_select     = s_reg.ba;
  assign pins.addr            = s_reg.addr;
  assign pins.low_byte_mask   = s_reg.dqm[0];
  assign pins.high_byte_mask  = s_reg.dqm[NL-1];
  assign pins.ctl_dq_out      = s_reg.dq;
  assign pins.ctl_dq_oe       = s_reg.dq_oe;
  assign req_ready            = s_reg.ready;
  assign rsp_valid            = s_reg.rsp_v;
  assign rsp_rdata            = s_reg.rsp_d;
  assign asleep               = (s_reg.st == CS_SLP);
endmodule

// file: verification/sdp_link_properties.sv
// sdp_link_properties.sv: timing relations on the pins between the
// controller end and the device end.
// assumes it sits beside the link interface and shares its clock.
`timescale 1ns/1ps
`include "sdp_regs.svh"
module sdp_link_properties
  import sdp_pkg::*;
#(
  parameter int NL = 2
) (
  input logic          clk,
  input logic          rst_n,
  input logic          clock_gate,
  input logic          chip_sel_n,
  input logic          row_strobe_n,
  input logic          column_strobe_n,
  input logic          write_strobe_n,
  input logic [1:0]    bank_select,
  input logic [11:0]   addr,
  input logic          low_byte_mask,
  input logic          high_byte_mask,
  input logic          ctl_dq_oe,
  input logic [NL-1:0] dev_dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // command as the controller drives it on the four strobes
  logic [3:0] cmd;
  logic       col_cmd;
  assign cmd = {chip_sel_n, row_strobe_n, column_strobe_n, write_strobe_n};
  assign col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);

  // every reset release is followed by a mode load of burst 1, latency 2
  property p_mode_load;
    $rose(rst_n) |-> ##[1:3] (cmd == CMD_LMR && addr == `SDP_MODE_RST);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode load missing after reset");

  // row open, two idle cycles, then a column access with auto precharge
  property p_act_to_column;
    cmd == CMD_ACT |=> (cmd == CMD_NOP) [*2] ##1
      (col_cmd && addr[`SDP_AP_BIT] && bank_select == $past(bank_select, 3));
  endproperty
  a_act_to_column: assert property (p_act_to_column)
    else $error("activate not followed by column access");

  // the bank closes by itself, so the pins stay idle while it recovers
  property p_column_recovery;
    col_cmd |=> (cmd == CMD_NOP) [*2];
  endproperty
  a_column_recovery: assert property (p_column_recovery)
    else $error("command during auto precharge");

  // unmasked read drives both lanes for exactly one burst word
  property p_read_drive;
    (cmd == CMD_RD && !low_byte_mask && !high_byte_mask) |->
      ##2 (dev_dq_oe == {NL{1'b1}}) ##1 (dev_dq_oe == '0);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data window wrong");

  // a mask floats its lane two cycles after it is sampled
  property p_low_mask_float;
    low_byte_mask |-> ##2 !dev_dq_oe[0];
  endproperty
  a_low_mask_float: assert property (p_low_mask_float)
    else $error("low lane driven under mask");

  property p_high_mask_float;
    high_byte_mask |-> ##2 !dev_dq_oe[NL-1];
  endproperty
  a_high_mask_float: assert property (p_high_mask_float)
    else $error("high lane driven under mask");

  // write data comes from the controller alone
  property p_write_drive;
    cmd == CMD_WR |-> ctl_dq_oe && dev_dq_oe == '0;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write cycle without controller data");

  // a stopped clock leaves the data bus undriven by both ends
  property p_sleep_quiet;
    (!clock_gate ##1 !clock_gate) |-> dev_dq_oe == '0 && !ctl_dq_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("data bus driven while clock stopped");
endmodule

// file: verification/sdram_pin_interface_test.sv
// sdram_pin_interface_test.sv: self-checking bench, controller and device
// joined by the pin interface.
// assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
module sdram_pin_interface_test;
  import sdp_pkg::*;
  localparam int LIMIT = 3000;
  typedef struct packed {
    logic        wr;
    logic [1:0]  bank;
    logic [11:0] row;
    logic [11:0] col;
    logic [15:0] data;
    logic [1:0]  mask;
    logic [15:0] exp;
  } sdp_row_t;

  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        req_valid = 1'h0;
  logic        req_write = 1'h0;
  logic [1:0]  req_bank = 2'h0;
  logic [11:0] req_row = 12'h0;
  logic [11:0] req_col = 12'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0]  req_mask = 2'h0;
  logic        sleep_req = 1'h0;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        asleep;
  sdp_pwr_t    power_state;
  logic [3:0]  bank_open;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [3:0]  pcmd;
  logic [1:0]  pmask;

  // writes to all banks, masked lanes, then reads back; the last read
  // uses the top column on the pins, which aliases onto column 7
  sdp_row_t rows [12] = '{
    '{1'h1, 2'h0, 12'h001, 12'h002, 16'h1234, 2'h0, 16'h0},
    '{1'h1, 2'h1, 12'h002, 12'h003, 16'hABCD, 2'h0, 16'h0},
    '{1'h1, 2'h2, 12'h003, 12'h007, 16'h5A5A, 2'h1, 16'h0},
    '{1'h1, 2'h3, 12'h000, 12'h000, 16'hFFFF, 2'h2, 16'h0},
    '{1'h1, 2'h0, 12'h001, 12'h002, 16'h0000, 2'h3, 16'h0},
    '{1'h1, 2'h0, 12'h002, 12'h002, 16'h0F0F, 2'h0, 16'h0},
    '{1'h0, 2'h0, 12'h001, 12'h002, 16'h0, 2'h0, 16'h1234},
    '{1'h0, 2'h1, 12'h002, 12'h003, 16'h0, 2'h0, 16'hABCD},
    '{1'h0, 2'h2, 12'h003, 12'h007, 16'h0, 2'h0, 16'h5A00},
    '{1'h0, 2'h3, 12'h000, 12'h000, 16'h0, 2'h0, 16'h00FF},
    '{1'h0, 2'h0, 12'h002, 12'h002, 16'h0, 2'h0, 16'h0F0F},
    '{1'h0, 2'h2, 12'h003, 12'h1FF, 16'h0, 2'h0, 16'h5A00}
  };

  sdp_if #(.DQ_W(16)) link ();

  sdp_ctl sdp_ctl_i (
    .clk(clk), .rst_n(rst_n), .pins(link.ctl), .req_valid(req_valid),
    .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
    .req_col(req_col), .req_wdata(req_wdata), .req_mask(req_mask),
    .sleep_req(sleep_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .asleep(asleep)
  );
  sdp_dev sdp_dev_i (
    .clk(clk), .rst_n(rst_n), .pins(link.dev),
    .power_state(power_state),
    .bank_open(bank_open)
  );
  sdp_link_properties #(.NL(2)) sdp_link_properties_i (
    .clk(clk), .rst_n(rst_n), .clock_gate(link.clock_gate),
    .chip_sel_n(link.chip_sel_n), .row_strobe_n(link.row_strobe_n),
    .column_strobe_n(link.column_strobe_n),
    .write_strobe_n(link.write_strobe_n), .bank_select(link.bank_select),
    .addr(link.addr), .low_byte_mask(link.low_byte_mask),
    .high_byte_mask(link.high_byte_mask), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe)
  );

  // command and masks as seen on the wires
  assign pcmd = {link.chip_sel_n, link.row_strobe_n,
                 link.column_strobe_n, link.write_strobe_n};
  assign pmask = {link.high_byte_mask, link.low_byte_mask};

  always #2.5 clk = ~clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d", name, check_count);
  endtask

  // pins are read at the edge, before that edge's updates land
  task automatic wait_cmd(input logic [3:0] c);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pcmd !== c && n < 20);
    check("command", {12'h0, c}, {12'h0, pcmd});
  endtask

  // one request through the controller, followed again on the pins
  task automatic access(input sdp_row_t t);
    int n;
    n = 0;
    req_valid <= 1'h1;
    req_write <= t.wr;
    req_bank <= t.bank;
    req_row <= t.row;
    req_col <= t.col;
    req_wdata <= t.data;
    req_mask <= t.mask;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'h1 && n < 80);
    req_valid <= 1'h0;
    wait_cmd(CMD_ACT);
    check("bank", {14'h0, t.bank}, {14'h0, link.bank_select});
    check("row", {4'h0, t.row}, {4'h0, link.addr});
    wait_cmd(t.wr ? CMD_WR : CMD_RD);
    check("column", {7'h0, t.col[8:0]}, {7'h0, link.addr[8:0]});
    check("auto precharge", 16'h1, {15'h0, link.addr[10]});
    check("bank open", 16'h1, {15'h0, bank_open[t.bank]});
    if (t.wr) begin
      check("masks", {14'h0, t.mask}, {14'h0, pmask});
      check("write bus", t.data, link.dq);
    end else begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rsp_valid !== 1'h1 && n < 10);
      check("read data", t.exp, rsp_rdata);
      check("bank closed", 16'h0, {12'h0, bank_open});
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      access(rows[i]);
    end
    end_test("table");

    // sleep while idle: requests refused, data kept across the stop
    sleep_req <= 1'h1;
    req_valid <= 1'h1;
    repeat (40) @(posedge clk);
    check("gate", 16'h0, {15'h0, link.clock_gate});
    check("ready asleep", 16'h0, {15'h0, req_ready});
    check("asleep", 16'h1, {15'h0, asleep});
    check("lanes asleep", 16'h0, {14'h0, link.dev_dq_oe});
    check("power state", {13'h0, PS_PDN}, {13'h0, power_state});
    sleep_req <= 1'h0;
    access(rows[7]);
    check("power awake", {13'h0, PS_RUN}, {13'h0, power_state});
    end_test("sleep");

    // reset in mid-run clears the array and restarts the mode load
    rst_n <= 1'h0;
    repeat (20) @(posedge clk);
    check("reset gate", 16'h1, {15'h0, link.clock_gate});
    check("reset cmd", {12'h0, CMD_NOP}, {12'h0, pcmd});
    check("reset power", {13'h0, PS_RUN}, {13'h0, power_state});
    rst_n <= 1'h1;
    access(sdp_row_t'{1'h0, 2'h0, 12'h001, 12'h002, 16'h0, 2'h0,
                      16'h0});
    end_test("reset");
    final_report();
  end
endmodule
